// ---- inc/hv_ctl_pkg.sv ----
// constants and types shared by the high-voltage channel control block
package hv_ctl_pkg;
  localparam int          CLK_HZ           = 20_000_000;  // ref_clk rate in Hz
  localparam int          VWIDTH           = 16;          // volt and current code width
  localparam int          TWIDTH           = 10;          // trip time code width
  localparam int          ACC_WIDTH        = 25;          // ramp phase accumulator width
  localparam int          TRIP_UNIT_MS     = 100;         // one trip code step, in ms
  localparam int          TRIP_TICK_CYCLES = CLK_HZ / 1000 * TRIP_UNIT_MS;
  localparam logic [24:0] ACC_WRAP         = 25'(CLK_HZ); // one volt step per wrap
  localparam logic [9:0]  TRIP_CONST_CODE  = 10'h03E8;    // 1000: constant current
  localparam logic [15:0] VOLT_ZERO        = 16'h0000;
  localparam logic [9:0]  TRIP_RESET       = 10'h03E8;    // counter value after reset
  localparam logic        STYLE_KILL       = 1'b1;        // trip shutdown style codes
  localparam logic        STYLE_RAMP       = 1'b0;

  // channel state, one-hot
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_ON   = 3'b010,
    ST_TRIP = 3'b100
  } chan_state_t;
endpackage : hv_ctl_pkg

// ---- rtl/rate_limiter.sv ----
// slew-limited voltage demand generator with kill override
`timescale 1ns/1ps
`default_nettype none
module rate_limiter (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [15:0] target,
  input  wire logic [15:0] rise_rate,
  input  wire logic [15:0] fall_rate,
  input  wire logic        kill,
  output logic      [15:0] level_q,
  output logic             moving
);
  logic [24:0] acc_q;
  logic [24:0] acc_d;
  logic [24:0] acc_sum;
  logic [15:0] level_d;
  wire         going_up = target > level_q;
  wire  [15:0] rate     = going_up ? rise_rate : fall_rate;
  wire         step;

  // rate in V/s added each cycle; a wrap of CLK_HZ is one volt, so never faster than rate
  assign acc_sum = acc_q + {9'h0_00, rate};
  assign step    = acc_sum >= hv_ctl_pkg::ACC_WRAP;
  assign moving  = target != level_q;

  // next level: kill drops at once, otherwise one volt per wrap
  always_comb
  begin
    acc_d   = moving ? acc_sum : 25'h000_0000;
    level_d = level_q;
    if (kill)
    begin
      acc_d   = 25'h000_0000;
      level_d = hv_ctl_pkg::VOLT_ZERO;   // [RULE_19]
    end
    else if (moving && step)
    begin
      acc_d = acc_sum - hv_ctl_pkg::ACC_WRAP;
      if (going_up)
        level_d = level_q + 16'h0001;    // [RULE_05]
      else
        level_d = level_q - 16'h0001;    // [RULE_06]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_q   <= 25'h000_0000;
      level_q <= hv_ctl_pkg::VOLT_ZERO;
    end
    else if (clk_en)
    begin
      acc_q   <= acc_d;
      level_q <= level_d;
    end
  end

  a_ramp_one_volt : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_05]
    (clk_en && !kill) |=> (level_q - $past(level_q) == 16'h0000)
      || (level_q - $past(level_q) == 16'h0001) || ($past(level_q) - level_q == 16'h0001))
    else $error("demand moved more than one volt in a cycle");
  a_ramp_kill_zero : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_19]
    (clk_en && kill) |=> level_q == 16'h0000)
    else $error("kill did not drop demand to zero");
endmodule : rate_limiter
`default_nettype wire

// ---- rtl/hv_channel_output_control.sv ----
// per-channel control of a high-voltage output: setpoints, ramps, trip, power on/off
//
// Overview of operation
// (RULE_01) select low picks voltage setpoint a
// (RULE_02) select high picks voltage setpoint b
// (RULE_03) current select low applies limit a
// (RULE_04) current select high applies limit b
// (RULE_05) rises limited to rise rate
// (RULE_06) falls limited to fall rate
// (RULE_07) off, ramp trip, disable ramp to zero
// (RULE_08) trip code 1000 means constant current
// (RULE_09) programmable protection: current source at limit
// (RULE_10) fixed protection: source only at hardware maximum
// (RULE_11) finite trip: source, then switch off
// (RULE_12) reload trip counter on listed events
// (RULE_13) count down only during overcurrent
// (RULE_14) turn on only without interlock, when enabled
// (RULE_15) turn-on ramps from zero to setpoint
// (RULE_16) turning on clears alarms, re-arms counter
// (RULE_17) restart restores state or starts off
// (RULE_18) shutdown style only for trip switch-offs
// (RULE_19) kill drops at once, ramp slews
// (RULE_20) refuse setpoints above software ceiling
// (RULE_21) trip alarm set until on or clear
// (RULE_22) trip counter ticks in trip code units
`timescale 1ns/1ps
`default_nettype none
module hv_channel_output_control #(
  parameter int TRIP_TICK_CYCLES = hv_ctl_pkg::TRIP_TICK_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        voltage_select_input,
  input  wire logic        current_select_input,
  input  wire logic        interlock_pin,
  input  wire logic        outputs_enable_pin,
  input  wire logic        overcurrent_pin,
  input  wire logic        hw_current_max_pin,
  input  wire logic [15:0] voltage_setpoint_a,
  input  wire logic [15:0] voltage_setpoint_b,
  input  wire logic [15:0] current_limit_a,
  input  wire logic [15:0] current_limit_b,
  input  wire logic [15:0] software_voltage_ceiling,
  input  wire logic [15:0] rise_rate,
  input  wire logic [15:0] fall_rate,
  input  wire logic [9:0]  trip_time,
  input  wire logic        trip_time_wr,
  input  wire logic        channel_on_off,
  input  wire logic        on_off_wr,
  input  wire logic        restore_at_startup,
  input  wire logic        startup_pulse,
  input  wire logic        alarm_clear,
  input  wire logic        trip_shutdown_style,
  input  wire logic        programmable_protection,
  output logic      [15:0] voltage_demand,
  output logic      [15:0] current_limit_setting,
  output logic             current_source_active,
  output logic             channel_active,
  output logic             trip_alarm,
  output logic             setpoint_refused,
  output logic             ramping,
  output logic      [9:0]  trip_count
);
  // pin synchronisers: first stage feeds only the second
  logic [5:0] pins_meta_q;
  logic [5:0] pins_q;
  wire  [5:0] pins_raw = {hw_current_max_pin, overcurrent_pin, outputs_enable_pin,
                          interlock_pin, current_select_input, voltage_select_input};
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pins_meta_q <= 6'h00;
      pins_q      <= 6'h00;
    end
    else if (clk_en)
    begin
      pins_meta_q <= pins_raw;
      pins_q      <= pins_meta_q;
    end
  end
  wire v2nd_s   = pins_q[0];
  wire i2nd_s   = pins_q[1];
  wire ilock_s  = pins_q[2];
  wire enable_s = pins_q[3];
  wire oc_s     = pins_q[4];
  wire hwmax_s  = pins_q[5];

  hv_ctl_pkg::chan_state_t state_q;
  hv_ctl_pkg::chan_state_t state_d;
  logic [15:0] accepted_q;
  logic [15:0] ilimit_q;
  logic [9:0]  count_q;
  logic [9:0]  count_d;
  logic        oc_prev_q;
  logic        alarm_q;
  logic        kill_q;
  logic        source_q;
  logic        refused_q;
  logic [31:0] tick_q;
  logic [15:0] target;

  // setpoint selection and ceiling check
  wire [15:0] sel_volt   = v2nd_s ? voltage_setpoint_b : voltage_setpoint_a; // [RULE_01] [RULE_02]
  wire [15:0] sel_limit  = i2nd_s ? current_limit_b : current_limit_a;       // [RULE_03] [RULE_04]
  wire        over_ceil  = sel_volt > software_voltage_ceiling;              // [RULE_20]

  // power control requests
  wire        may_run    = !ilock_s && enable_s;
  wire        turn_on    = on_off_wr && channel_on_off && may_run;           // [RULE_14]
  wire        turn_off   = on_off_wr && !channel_on_off;
  wire        restore_on = startup_pulse && restore_at_startup
                           && channel_on_off && may_run;                     // [RULE_17]
  wire        is_on      = state_q == hv_ctl_pkg::ST_ON;

  // trip timing: 1000 holds off the trip forever
  wire        const_mode = trip_time == hv_ctl_pkg::TRIP_CONST_CODE;         // [RULE_08]
  wire        tick       = tick_q == 32'(TRIP_TICK_CYCLES - 1);              // [RULE_22]
  wire        oc_end     = oc_prev_q && !oc_s && (count_q != 10'h000);
  wire        reload     = trip_time_wr || alarm_clear || turn_on || oc_end; // [RULE_12] [RULE_16]
  wire        trip_evt   = is_on && oc_s && !const_mode
                           && (count_q == 10'h000) && !reload;               // [RULE_11]

  // the trip code unit time base
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      tick_q <= 32'h0000_0000;
    else if (clk_en)
      tick_q <= tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
  end

  // trip counter: reload wins, count only while overcurrent, stop at zero
  always_comb
  begin
    count_d = count_q;
    if (reload)
      count_d = trip_time;                                                   // [RULE_12]
    else if (oc_s && tick && (count_q != 10'h000))
      count_d = count_q - 10'h001;                                           // [RULE_13]
  end

  // channel state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      hv_ctl_pkg::ST_OFF:
        if (turn_on || restore_on)
          state_d = hv_ctl_pkg::ST_ON;
      hv_ctl_pkg::ST_ON:
        if (trip_evt)
          state_d = hv_ctl_pkg::ST_TRIP;
        else if (turn_off || !may_run)
          state_d = hv_ctl_pkg::ST_OFF;                                      // [RULE_07]
      hv_ctl_pkg::ST_TRIP:
        if (turn_on)
          state_d = hv_ctl_pkg::ST_ON;
        else if (alarm_clear || turn_off)
          state_d = hv_ctl_pkg::ST_OFF;
      default:
        state_d = hv_ctl_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q   <= hv_ctl_pkg::ST_OFF;                                       // [RULE_17]
      count_q   <= hv_ctl_pkg::TRIP_RESET;
      oc_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q   <= state_d;
      count_q   <= count_d;
      oc_prev_q <= oc_s;
    end
  end

  // trip alarm: a clear in the same cycle as a trip condition reloads the counter and blocks the trip
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      alarm_q <= 1'b0;
    else if (clk_en)
    begin
      if (trip_evt)
        alarm_q <= 1'b1;                                                     // [RULE_21]
      else if (alarm_clear || turn_on)
        alarm_q <= 1'b0;                                                     // [RULE_16]
    end
  end

  // kill only follows a trip; ordinary switch-offs always ramp
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      kill_q <= 1'b0;
    else if (clk_en)
    begin
      if (trip_evt)
        kill_q <= trip_shutdown_style == hv_ctl_pkg::STYLE_KILL;            // [RULE_18] [RULE_19]
      else if (state_d != hv_ctl_pkg::ST_TRIP)
        kill_q <= 1'b0;
    end
  end

  // accepted setpoint holds the last value within the ceiling
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      accepted_q <= hv_ctl_pkg::VOLT_ZERO;
      refused_q  <= 1'b0;
      ilimit_q   <= 16'h0000;
    end
    else if (clk_en)
    begin
      refused_q <= over_ceil;
      ilimit_q  <= sel_limit;                                                // [RULE_03] [RULE_04]
      if (!over_ceil)
        accepted_q <= sel_volt;                                              // [RULE_20]
    end
  end

  // current source indication depends on the protection fitted
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      source_q <= 1'b0;
    else if (clk_en)
      source_q <= is_on && oc_s && (programmable_protection || hwmax_s);    // [RULE_09] [RULE_10]
  end

  // off and tripped states steer the ramp to zero
  assign target = is_on ? accepted_q : hv_ctl_pkg::VOLT_ZERO;               // [RULE_07] [RULE_15]

  rate_limiter u_ramp (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .target    (target),
    .rise_rate (rise_rate),
    .fall_rate (fall_rate),
    .kill      (kill_q),
    .level_q   (voltage_demand),
    .moving    (ramping)
  );

  assign current_limit_setting = ilimit_q;
  assign current_source_active = source_q;
  assign channel_active        = is_on;
  assign trip_alarm            = alarm_q;
  assign setpoint_refused      = refused_q;
  assign trip_count            = count_q;

  a_trip_sets_alarm : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_21]
    (clk_en && trip_evt) |=> trip_alarm && state_q == hv_ctl_pkg::ST_TRIP)
    else $error("trip did not raise alarm and leave on state");
  a_const_no_trip : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_08]
    (clk_en && is_on && const_mode && !turn_off && may_run)
      |=> state_q == hv_ctl_pkg::ST_ON)
    else $error("constant current mode switched channel off");
  a_on_needs_enable : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_14]
    (clk_en && state_q == hv_ctl_pkg::ST_OFF && (ilock_s || !enable_s))
      |=> state_q == hv_ctl_pkg::ST_OFF)
    else $error("channel turned on under interlock or disable");
  a_reload_value : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_12]
    (clk_en && reload) |=> trip_count == $past(trip_time))
    else $error("trip counter not reloaded");
  a_count_hold : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_13]
    (clk_en && !reload && !oc_s) |=> trip_count == $past(trip_count))
    else $error("trip counter moved without overcurrent");
  a_turn_on_clear : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_16]
    (clk_en && turn_on && !trip_evt) |=> !trip_alarm)
    else $error("turn on did not clear alarm");
  a_ramp_only_kill : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_18]
    kill_q |-> state_q == hv_ctl_pkg::ST_TRIP)
    else $error("kill active outside a trip shutdown");
  a_ceiling_kept : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_20]
    (clk_en && over_ceil) |=> accepted_q == $past(accepted_q) && setpoint_refused)
    else $error("setpoint above ceiling accepted");
  a_volt_pick_low : assert property (@(posedge ref_clk) disable iff (!arst_n) // [RULE_01]
    (clk_en && !v2nd_s && !over_ceil) |=> accepted_q == $past(voltage_setpoint_a))
    else $error("select low did not take setpoint a");
endmodule : hv_channel_output_control
`default_nettype wire

// ---- verification/hv_stage_model.sv ----
// behavioural analog output stage: load current measured against the selected limit
`timescale 1ns/1ps
`default_nettype none
module hv_stage_model #(
  parameter logic [15:0] HW_MAX = 16'h00C8
) (
  input  wire logic [15:0] voltage_demand,
  input  wire logic [15:0] current_limit_setting,
  input  wire logic [15:0] load_current,
  output logic             overcurrent_pin,
  output logic             hw_current_max_pin
);
  // no current can flow while the demand is zero, so neither flag may rise then
  wire logic live;
  assign live               = (voltage_demand != 16'h0000);
  assign overcurrent_pin    = live && (load_current > current_limit_setting);
  assign hw_current_max_pin = live && (load_current >= HW_MAX);
endmodule : hv_stage_model
`default_nettype wire

// ---- verification/hv_channel_output_control_tb.sv ----
// self-checking bench for the high-voltage channel control block
`timescale 1ns/1ps
`default_nettype none
module hv_channel_output_control_tb;
  logic ref_clk = 0, arst_n = 0, v2nd = 0, i2nd = 0, ilk = 0, oen = 1, ce = 1;
  logic ovc, hwm, t_wr = 0, on = 0, on_wr = 0, rst_on = 0, sp = 0, clr = 0;
  logic kill = 1, prog = 1, csa, act, alarm, refused, ramping;
  logic [15:0] va = 16'h0004, vb = 16'h0002, la = 16'h0010, lb = 16'h0020;
  logic [15:0] load = 16'h0000, dem, lim;
  logic [9:0]  trip = 10'h0002, tcnt;
  int fail_count = 0, samples_checked = 0;

  // slow ramps keep every volt step a few hundred cycles apart
  always #25 ref_clk = ~ref_clk;

  hv_channel_output_control #(.TRIP_TICK_CYCLES(10)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(ce), .voltage_select_input(v2nd),
    .current_select_input(i2nd), .interlock_pin(ilk), .outputs_enable_pin(oen),
    .overcurrent_pin(ovc), .hw_current_max_pin(hwm), .voltage_setpoint_a(va),
    .voltage_setpoint_b(vb), .current_limit_a(la), .current_limit_b(lb),
    .software_voltage_ceiling(16'h000A), .rise_rate(16'hFFFF), .fall_rate(16'hFFFF),
    .trip_time(trip), .trip_time_wr(t_wr), .channel_on_off(on), .on_off_wr(on_wr),
    .restore_at_startup(rst_on), .startup_pulse(sp), .alarm_clear(clr),
    .trip_shutdown_style(kill), .programmable_protection(prog), .voltage_demand(dem),
    .current_limit_setting(lim), .current_source_active(csa), .channel_active(act),
    .trip_alarm(alarm), .setpoint_refused(refused), .ramping(ramping), .trip_count(tcnt));

  hv_stage_model stage (.voltage_demand(dem), .current_limit_setting(lim),
    .load_current(load), .overcurrent_pin(ovc), .hw_current_max_pin(hwm));

  task automatic chk1(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk16

  // one-cycle pulse, launched and dropped on falling edges
  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
    @(negedge ref_clk);
  endtask : pulse

  // bounded wait; running out counts as a mismatch
  task automatic wait_until(const ref logic s, input logic v, input int n);
    int i;
    for (i = 0; i < n && s !== v; i++) @(negedge ref_clk);
    chk1("wait", v, s);
  endtask : wait_until

  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : settle

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // a hang is cut short well beyond the expected run length
  initial
  begin
    #(40000 * 50);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    settle(10);
    arst_n = 1;
    chk16("count", 16'h03E8, {6'h00, tcnt});
    chk1("active", 1'b0, act);
    done("reset");
    i2nd = 1;
    settle(4);
    chk16("limit", 16'h0020, lim);
    i2nd = 0;
    settle(4);
    chk16("limit", 16'h0010, lim);
    done("limits");
    on = 1;
    pulse(on_wr);
    chk1("active", 1'b1, act);
    chk16("count", 16'h0002, {6'h00, tcnt});
    settle(100);
    chk1("slow rise", 1'b1, dem <= 16'h0001);
    // enable low must hold the ramp at zero through the time of the first volt step
    ce = 0;
    settle(400);
    chk16("frozen", 16'h0000, dem);
    ce = 1;
    wait_until(ramping, 1'b0, 3000);
    chk16("demand", 16'h0004, dem);
    v2nd = 1;
    settle(4);
    wait_until(ramping, 1'b0, 3000);
    chk16("demand", 16'h0002, dem);
    done("ramps");
    vb = 16'h000B;
    settle(4);
    chk1("refused", 1'b1, refused);
    chk16("demand", 16'h0002, dem);
    vb = 16'h0002;
    done("ceiling");
    load = 16'h0018;
    settle(4);
    chk1("source", 1'b1, csa);
    wait_until(alarm, 1'b1, 200);
    chk1("active", 1'b0, act);
    settle(2);
    chk16("demand", 16'h0000, dem);
    pulse(clr);
    chk1("alarm", 1'b0, alarm);
    chk16("count", 16'h0002, {6'h00, tcnt});
    done("kill trip");
    trip = 10'h03E8;
    pulse(t_wr);
    pulse(on_wr);
    // long enough for the counter to run out while overcurrent persists
    settle(10500);
    chk16("count", 16'h0000, {6'h00, tcnt});
    chk1("active", 1'b1, act);
    chk1("alarm", 1'b0, alarm);
    prog = 0;
    settle(4);
    chk1("source", 1'b0, csa);
    load = 16'h00C8;
    settle(4);
    chk1("source", 1'b1, csa);
    done("constant current");
    prog = 1;
    wait_until(ramping, 1'b0, 3000);
    kill = 0;
    trip = 10'h0001;
    pulse(t_wr);
    wait_until(alarm, 1'b1, 200);
    settle(5);
    chk1("slewing", 1'b1, dem != 16'h0000);
    wait_until(ramping, 1'b0, 3000);
    chk16("demand", 16'h0000, dem);
    done("ramp trip");
    load = 16'h0000;
    pulse(clr);
    ilk = 1;
    settle(4);
    pulse(on_wr);
    chk1("active", 1'b0, act);
    ilk = 0;
    settle(4);
    pulse(on_wr);
    wait_until(ramping, 1'b0, 3000);
    oen = 0;
    settle(4);
    chk1("active", 1'b0, act);
    wait_until(ramping, 1'b0, 3000);
    chk16("demand", 16'h0000, dem);
    oen = 1;
    done("enables");
    arst_n = 0;
    rst_on = 1;
    settle(2);
    arst_n = 1;
    settle(4);
    pulse(sp);
    chk1("restored", 1'b1, act);
    arst_n = 0;
    rst_on = 0;
    settle(2);
    arst_n = 1;
    settle(4);
    pulse(sp);
    chk1("restored", 1'b0, act);
    done("restart");
    wrap_up();
  end
endmodule : hv_channel_output_control_tb
`default_nettype wire
